// [include/tvws_pkg.sv]
/*
 * tvws_pkg: register indices, field positions, reset values and scaling
 * constants of the tv-output control and video window scale block.
 * assumes: an 8-bit indexed host port; dot clock is the only clock.
 */
package tvws_pkg;

	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [7:0] TVWS_IDX_TV_OUTPUT_CONTROL      = 8'h30;
	localparam logic [7:0] TVWS_IDX_WINDOW_HSCALE_COEF_LOW = 8'h31;
	localparam logic [7:0] TVWS_IDX_WINDOW_VSCALE_COEF_LOW = 8'h32;

	// ---------------------------------------------------------------
	// reset values and masks
	// ---------------------------------------------------------------
	localparam logic [7:0] TVWS_RST_TV_OUTPUT_CONTROL = 8'h00;
	localparam logic [7:0] TVWS_RST_COEF_LOW          = 8'h00;
	localparam logic [7:0] TVWS_CTRL_RD_MASK          = 8'hbf;
	localparam logic [7:0] TVWS_RD_UNMAPPED           = 8'h00;

	// ---------------------------------------------------------------
	// control field layout
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       aux_level;
		logic       reserved;
		logic [1:0] htotal_delay;
		logic       tv_enable;
		logic       ntsc_select;
		logic [1:0] composite_sync_out_delay;
	} tvws_ctrl_t;

	// split of the extension byte carrying the coefficient high nibbles
	localparam int TVWS_HI_H_LSB = 0;
	localparam int TVWS_HI_V_LSB = 4;
	localparam int TVWS_HI_W     = 4;

	// ---------------------------------------------------------------
	// delay lines and scaling
	// ---------------------------------------------------------------
	localparam int          TVWS_DLY_STEP  = 2;
	localparam int          TVWS_DLY_MAX   = 6;
	localparam int          TVWS_COEF_W    = 12;
	localparam logic [12:0] TVWS_UNITY_STEP = 13'h1000;
	localparam logic [11:0] TVWS_COEF_ZERO  = 12'h000;
	localparam logic [11:0] TVWS_COEF_4X    = 12'h400;
	localparam int          TVWS_4X_GAP     = 3;

endpackage : tvws_pkg

// [hdl/tvws_ctrl.sv]
/*
 * tvws_ctrl: tv-output side-band pins, horizontal total and composite
 * sync delay lines, and window up-scaling steppers with horizontal interpolation.
 * assumes: clk is the dot clock; host index port and all timing inputs
 * are synchronous to it; the coefficient high byte and the power
 * override bit live in registers outside this block.
 */
// Behaviour
// (R01) aux level pin follows control bit 7.
// (R02) horizontal total delayed 0, 2, 4 or 6 dot clocks by bits 5:4.
// (R03) tv output disabled: power-on, standard and sync outputs low.
// (R04) tv output enabled: power-on high, sync generated for chosen standard.
// (R05) power override set: power-on pin no longer follows enable bit.
// (R06) standard bit 0 gives pal and low pin, 1 ntsc and high pin.
// (R07) standard bit ignored while tv output disabled.
// (R08) composite sync delayed 0, 2, 4 or 6 dot clocks by bits 1:0.
// (R09) horizontal coefficient is high nibble bits 3:0 over low register.
// (R10) horizontal enlargement is 4096 over coefficient, 1x to 4x.
// (R11) horizontal coefficient zero means no horizontal enlargement.
// (R12) horizontal enlargement interpolates extra pixels, window grows wider.
// (R13) vertical coefficient is high nibble bits 7:4 over low register.
// (R14) vertical enlargement is 4096 over coefficient.
// (R15) vertical coefficient zero means unscaled vertical output.
// (R16) vertical enlargement repeats scanlines, window height stays fixed.
// (R17) software keeps nonzero coefficients within 1024 to 4095.
`timescale 1ns/1ps

module tvws_ctrl
	import tvws_pkg::*;
#(
	parameter int PIX_W = 8
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// host index port
	input  wire logic [7:0]       reg_index,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	// neighbouring extension registers
	input  wire logic [7:0]       window_scale_coef_high,
	input  wire logic             power_override,
	input  wire logic             power_override_level,
	// raw timing from the sync generator
	input  wire logic             htotal_in,
	input  wire logic             composite_sync_out_pal_in,
	input  wire logic             composite_sync_out_ntsc_in,
	// tv encoder side-band pins
	output logic                  aux_level_pin,
	output logic                  encoder_power_on,
	output logic                  tv_standard_pin,
	output logic                  composite_sync_out,
	output logic                  htotal_out,
	// horizontal scaler
	input  wire logic             pix_en,
	input  wire logic [PIX_W-1:0] src_pix_a,
	input  wire logic [PIX_W-1:0] src_pix_b,
	output logic                  src_pix_advance,
	output logic      [PIX_W-1:0] video_window_pix,
	// vertical scaler
	input  wire logic             frame_start,
	input  wire logic             line_start,
	output logic                  src_line_advance
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	tvws_ctrl_t        ctrl_ff;
	logic [7:0]        hlow_ff;
	logic [7:0]        vlow_ff;
	logic [7:0]        rdata_ff;
	logic [TVWS_DLY_MAX-1:0] ht_sr_ff;
	logic [TVWS_DLY_MAX-1:0] cs_sr_ff;
	logic              ht_out_ff;
	logic              cs_out_ff;
	logic [TVWS_COEF_W-1:0] hacc_ff;
	logic [TVWS_COEF_W-1:0] vacc_ff;
	logic [PIX_W-1:0]  pix_ff;

	// ---------------------------------------------------------------
	// index decode and read mux
	// ---------------------------------------------------------------
	wire logic  sel_ctrl = reg_index == TVWS_IDX_TV_OUTPUT_CONTROL;
	wire logic  sel_h    = reg_index == TVWS_IDX_WINDOW_HSCALE_COEF_LOW;
	wire logic  sel_v    = reg_index == TVWS_IDX_WINDOW_VSCALE_COEF_LOW;
	wire logic [7:0] nxt_rdata = sel_ctrl ? (ctrl_ff & TVWS_CTRL_RD_MASK) :
	                             sel_h    ? hlow_ff :
	                             sel_v    ? vlow_ff : TVWS_RD_UNMAPPED;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_ff  <= TVWS_RST_TV_OUTPUT_CONTROL;
			hlow_ff  <= TVWS_RST_COEF_LOW;
			vlow_ff  <= TVWS_RST_COEF_LOW;
			rdata_ff <= TVWS_RD_UNMAPPED;
		end
		else
		begin
			if (reg_wr && sel_ctrl)
				ctrl_ff <= reg_wdata & TVWS_CTRL_RD_MASK;
			if (reg_wr && sel_h)
				hlow_ff <= reg_wdata;
			if (reg_wr && sel_v)
				vlow_ff <= reg_wdata;
			if (reg_rd)
				rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// ---------------------------------------------------------------
	// side-band pins
	// ---------------------------------------------------------------
	assign aux_level_pin    = ctrl_ff.aux_level; // see (R01)
	// override hands the pin to the power sequencer level
	assign encoder_power_on = power_override ? power_override_level // see (R05)
	                                         : ctrl_ff.tv_enable;   // see (R03) see (R04)
	assign tv_standard_pin  = ctrl_ff.tv_enable & ctrl_ff.ntsc_select; // see (R06) see (R07)

	// ---------------------------------------------------------------
	// delay lines: tap 0 is the input itself, then every second stage
	// ---------------------------------------------------------------
	wire logic cs_src = ctrl_ff.ntsc_select ? composite_sync_out_ntsc_in : composite_sync_out_pal_in; // see (R06)
	wire logic [TVWS_DLY_MAX:0] ht_taps = {ht_sr_ff, htotal_in};
	wire logic [TVWS_DLY_MAX:0] cs_taps = {cs_sr_ff, cs_src};
	wire logic [2:0] ht_tap_sel = 3'(ctrl_ff.htotal_delay * TVWS_DLY_STEP);
	wire logic [2:0] cs_tap_sel = 3'(ctrl_ff.composite_sync_out_delay * TVWS_DLY_STEP);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ht_sr_ff  <= '0;
			cs_sr_ff  <= '0;
			ht_out_ff <= 1'b0;
			cs_out_ff <= 1'b0;
		end
		else
		begin
			ht_sr_ff  <= ht_taps[TVWS_DLY_MAX-1:0];
			cs_sr_ff  <= cs_taps[TVWS_DLY_MAX-1:0];
			ht_out_ff <= ht_taps[ht_tap_sel];                     // see (R02)
			cs_out_ff <= ctrl_ff.tv_enable & cs_taps[cs_tap_sel]; // see (R08) see (R03) see (R04)
		end
	end

	assign htotal_out         = ht_out_ff;
	assign composite_sync_out = cs_out_ff;

	// ---------------------------------------------------------------
	// coefficients: zero stands for a full unity step
	// ---------------------------------------------------------------
	wire logic [TVWS_COEF_W-1:0] hcoef =
		{window_scale_coef_high[TVWS_HI_H_LSB +: TVWS_HI_W], hlow_ff}; // see (R09)
	wire logic [TVWS_COEF_W-1:0] vcoef =
		{window_scale_coef_high[TVWS_HI_V_LSB +: TVWS_HI_W], vlow_ff}; // see (R13)
	wire logic [12:0] hstep = (hcoef == TVWS_COEF_ZERO) ? TVWS_UNITY_STEP : {1'b0, hcoef}; // see (R11)
	wire logic [12:0] vstep = (vcoef == TVWS_COEF_ZERO) ? TVWS_UNITY_STEP : {1'b0, vcoef}; // see (R15)

	// ---------------------------------------------------------------
	// horizontal stepper and interpolator
	// ---------------------------------------------------------------
	// a source pixel is consumed each time the phase wraps 4096
	wire logic [12:0] hsum = {1'b0, hacc_ff} + hstep; // see (R10)
	assign src_pix_advance = pix_en & hsum[TVWS_COEF_W];

	// weighted blend of the two neighbours by the current phase
	wire logic [12:0] wa = TVWS_UNITY_STEP - {1'b0, hacc_ff};
	wire logic [PIX_W+12:0] blend = (PIX_W+13)'(src_pix_a * wa) + (PIX_W+13)'(src_pix_b * hacc_ff);
	wire logic [PIX_W-1:0] nxt_pix = blend[TVWS_COEF_W +: PIX_W]; // see (R12)

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hacc_ff <= '0;
			pix_ff  <= '0;
		end
		else if (line_start)
			hacc_ff <= '0;
		else if (pix_en)
		begin
			hacc_ff <= hsum[TVWS_COEF_W-1:0]; // see (R10)
			pix_ff  <= nxt_pix;               // see (R12)
		end
	end

	assign video_window_pix = pix_ff;

	// ---------------------------------------------------------------
	// vertical stepper: lines are repeated, the height is not changed
	// ---------------------------------------------------------------
	wire logic [12:0] vsum = {1'b0, vacc_ff} + vstep; // see (R14)
	assign src_line_advance = line_start & vsum[TVWS_COEF_W]; // see (R16)

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			vacc_ff <= '0;
		else if (frame_start)
			vacc_ff <= '0;
		else if (line_start)
			vacc_ff <= vsum[TVWS_COEF_W-1:0]; // see (R14)
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic [2:0] hgap_ff;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hgap_ff <= '0;
		else if (line_start || src_pix_advance)
			hgap_ff <= '0;
		else if (pix_en)
			hgap_ff <= hgap_ff + 3'h1;
	end

	// coefficient that gives an exact 2x enlargement
	localparam logic [TVWS_COEF_W-1:0] TVWS_COEF_2X = TVWS_COEF_4X << 1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_ht6;
		ctrl_ff.htotal_delay == 2'b11 [*8];
	endsequence
	sequence s_cs0;
		ctrl_ff.composite_sync_out_delay == 2'b00 && ctrl_ff.tv_enable [*2];
	endsequence
	sequence s_ht0;
		ctrl_ff.htotal_delay == 2'b00 [*2];
	endsequence
	sequence s_ht2;
		ctrl_ff.htotal_delay == 2'b01 [*4];
	endsequence
	sequence s_ht4;
		ctrl_ff.htotal_delay == 2'b10 [*6];
	endsequence
	sequence s_cs2;
		ctrl_ff.composite_sync_out_delay == 2'b01 && ctrl_ff.tv_enable [*4];
	endsequence
	sequence s_cs4;
		ctrl_ff.composite_sync_out_delay == 2'b10 && ctrl_ff.tv_enable [*6];
	endsequence
	sequence s_cs6;
		ctrl_ff.composite_sync_out_delay == 2'b11 && ctrl_ff.tv_enable [*8];
	endsequence

	AST_AUX_PIN: assert property ( // see (R01)
		reg_wr && sel_ctrl |=> aux_level_pin == $past(reg_wdata[7]))
		else $error("aux pin does not follow written bit");
	AST_HT_DELAY6: assert property ( // see (R02)
		s_ht6 |-> htotal_out == $past(htotal_in, 7))
		else $error("horizontal total delay wrong at code 3");
	AST_TV_OFF: assert property ( // see (R03)
		!ctrl_ff.tv_enable && $past(!ctrl_ff.tv_enable) |->
		!tv_standard_pin && !composite_sync_out && (power_override || !encoder_power_on))
		else $error("outputs not low while tv output disabled");
	AST_TV_ON: assert property ( // see (R04)
		ctrl_ff.tv_enable && !power_override |-> encoder_power_on)
		else $error("power-on low while tv output enabled");
	AST_OVERRIDE: assert property ( // see (R05)
		power_override |-> encoder_power_on == power_override_level)
		else $error("power-on pin still follows enable under override");
	AST_STD_PIN: assert property ( // see (R06)
		ctrl_ff.tv_enable |-> tv_standard_pin == ctrl_ff.ntsc_select)
		else $error("standard pin does not follow select bit");
	AST_CS_NODELAY: assert property ( // see (R08)
		s_cs0 |-> composite_sync_out ==
		($past(ctrl_ff.ntsc_select) ? $past(composite_sync_out_ntsc_in) : $past(composite_sync_out_pal_in)))
		else $error("composite sync wrong at zero delay");
	AST_HCOEF: assert property ( // see (R09)
		hcoef[TVWS_COEF_W-1 -: TVWS_HI_W] == window_scale_coef_high[3:0] && hcoef[7:0] == hlow_ff)
		else $error("horizontal coefficient assembled wrongly");
	AST_H_UNITY: assert property ( // see (R11)
		pix_en && !line_start && hcoef == TVWS_COEF_ZERO && hacc_ff == TVWS_COEF_ZERO |->
		src_pix_advance ##1 hacc_ff == TVWS_COEF_ZERO)
		else $error("zero horizontal coefficient does not step every pixel");
	AST_H_4X: assert property ( // see (R10)
		src_pix_advance && hcoef == TVWS_COEF_4X && $past(src_pix_advance) == 1'b0 &&
		hacc_ff != TVWS_COEF_ZERO |-> hgap_ff == 3'(TVWS_4X_GAP))
		else $error("4x coefficient does not consume one pixel per four");
	AST_INTERP: assert property ( // see (R12)
		pix_en && !line_start && hacc_ff == TVWS_COEF_ZERO |=> video_window_pix == $past(src_pix_a))
		else $error("zero phase does not pass source pixel");
	AST_V_UNITY: assert property ( // see (R15)
		line_start && vcoef == TVWS_COEF_ZERO && vacc_ff == TVWS_COEF_ZERO |-> src_line_advance)
		else $error("zero vertical coefficient repeats a line");
	AST_V_REPEAT: assert property ( // see (R16)
		line_start && !frame_start && vcoef == TVWS_COEF_4X && vacc_ff == TVWS_COEF_ZERO |->
		!src_line_advance)
		else $error("4x vertical does not repeat the first line");

	// remaining delay codes against the raw input
	AST_HT_DELAY0: assert property ( // see (R02)
		s_ht0 |-> htotal_out == $past(htotal_in))
		else $error("horizontal total delay wrong at code 0");
	AST_HT_DELAY2: assert property ( // see (R02)
		s_ht2 |-> htotal_out == $past(htotal_in, 3))
		else $error("horizontal total delay wrong at code 1");
	AST_HT_DELAY4: assert property ( // see (R02)
		s_ht4 |-> htotal_out == $past(htotal_in, 5))
		else $error("horizontal total delay wrong at code 2");
	AST_CS_DELAY2: assert property ( // see (R08)
		s_cs2 |-> composite_sync_out == $past(cs_src, 3))
		else $error("composite sync delay wrong at code 1");
	AST_CS_DELAY4: assert property ( // see (R08)
		s_cs4 |-> composite_sync_out == $past(cs_src, 5))
		else $error("composite sync delay wrong at code 2");
	AST_CS_DELAY6: assert property ( // see (R08)
		s_cs6 |-> composite_sync_out == $past(cs_src, 7))
		else $error("composite sync delay wrong at code 3");
	AST_STD_IGNORED: assert property ( // see (R07)
		!ctrl_ff.tv_enable && $changed(ctrl_ff.ntsc_select) |->
		!tv_standard_pin ##1 !composite_sync_out)
		else $error("standard bit acts while tv output disabled");
	AST_VCOEF: assert property ( // see (R13)
		vcoef[TVWS_COEF_W-1 -: TVWS_HI_W] == window_scale_coef_high[7:4] && vcoef[7:0] == vlow_ff)
		else $error("vertical coefficient assembled wrongly");

	// scaler phase patterns
	AST_H_4X_PHASE: assert property ( // see (R10)
		pix_en && hcoef == TVWS_COEF_4X |->
		src_pix_advance == (hacc_ff[TVWS_COEF_W-1] && hacc_ff[TVWS_COEF_W-2]))
		else $error("4x horizontal advances at the wrong phase");
	AST_H_HOLD: assert property ( // see (R11)
		pix_en && !line_start && hcoef == TVWS_COEF_ZERO |=> hacc_ff == $past(hacc_ff))
		else $error("zero horizontal coefficient moves the phase");
	AST_V_2X: assert property ( // see (R14)
		line_start && vcoef == TVWS_COEF_2X |-> src_line_advance == vacc_ff[TVWS_COEF_W-1])
		else $error("2x vertical does not fetch every second line");
	AST_V_4X_PHASE: assert property ( // see (R16)
		line_start && vcoef == TVWS_COEF_4X |->
		src_line_advance == (vacc_ff[TVWS_COEF_W-1] && vacc_ff[TVWS_COEF_W-2]))
		else $error("4x vertical fetches at the wrong phase");
	AST_V_HOLD: assert property ( // see (R15)
		line_start && !frame_start && vcoef == TVWS_COEF_ZERO |=> vacc_ff == $past(vacc_ff))
		else $error("zero vertical coefficient moves the phase");

endmodule : tvws_ctrl

// [testbench/tvws_sync_model.sv]
/*
 * tvws_sync_model: raw sync generator ahead of the block; one pulse of
 * horizontal total and of the chosen standard's sync per request.
 * assumes: go and sel come from the bench, changed at falling edges.
 */
`timescale 1ns/1ps

module tvws_sync_model
(
	// request
	input  wire logic       go,
	input  wire logic [1:0] sel,
	// raw timing
	output logic            htotal_in,
	output logic            composite_sync_out_pal_in,
	output logic            composite_sync_out_ntsc_in
);
	// idle lines sit low between pulses
	assign htotal_in     = go;
	assign composite_sync_out_pal_in  = go & sel[0];
	assign composite_sync_out_ntsc_in = go & sel[1];
endmodule : tvws_sync_model

// [testbench/testbench.sv]
/*
 * testbench: self-checking bench for tvws_ctrl.
 * assumes: tvws_pkg compiled first; 40 MHz dot clock.
 */
`timescale 1ns/1ps

module testbench;
	import tvws_pkg::*;
	logic       clk, nrst, reg_wr, reg_rd, go, ovr, ovr_lvl, a;
	logic [7:0] reg_index, reg_wdata, reg_rdata, coef_hi, pa, pb, pix, v;
	logic [1:0] sel;
	logic [2:0] stb;
	logic       ht_i, cp_i, cn_i, aux, pwr, std, cs, ht, adv_p, adv_l;
	int         fail_count, tests_run, cyc, th, tc;

	tvws_sync_model i_tvws_sync_model (.go(go), .sel(sel), .htotal_in(ht_i),
		.composite_sync_out_pal_in(cp_i), .composite_sync_out_ntsc_in(cn_i));
	tvws_ctrl i_tvws_ctrl (.clk(clk), .nrst(nrst), .reg_index(reg_index),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.window_scale_coef_high(coef_hi), .power_override(ovr),
		.power_override_level(ovr_lvl), .htotal_in(ht_i), .composite_sync_out_pal_in(cp_i),
		.composite_sync_out_ntsc_in(cn_i), .aux_level_pin(aux), .encoder_power_on(pwr),
		.tv_standard_pin(std), .composite_sync_out(cs), .htotal_out(ht),
		.pix_en(stb[0]), .src_pix_a(pa), .src_pix_b(pb), .src_pix_advance(adv_p),
		.video_window_pix(pix), .frame_start(stb[2]), .line_start(stb[1]),
		.src_line_advance(adv_l));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task stop_test;
		$display("checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	task chk(input logic [7:0] g, input logic [7:0] e, input string m);
		tests_run++;
		if (g !== e)
		begin
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
			fail_count++;
		end
	endtask : chk

	task wr(input logic [7:0] i, input logic [7:0] d);
		@(negedge clk);
		reg_index = i;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] i, output logic [7:0] d);
		@(negedge clk);
		reg_index = i;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd

	// one strobe cycle {frame_start, line_start, pix_en}
	task step(input logic [2:0] s);
		@(negedge clk);
		stb = s;
		#1 a = s[0] ? adv_p : adv_l;
		@(negedge clk);
		stb = 3'h0;
	endtask : step

	// cycles from raw pulse to delayed outputs, 0 when none seen
	task meas(input logic [1:0] s);
		th = 0;
		tc = 0;
		@(negedge clk);
		sel = s;
		go = 1'b1;
		for (int k = 1; k < 10; k++)
		begin
			@(negedge clk);
			go = 1'b0;
			if (ht === 1'b1 && th == 0) th = k;
			if (cs === 1'b1 && tc == 0) tc = k;
		end
	endtask : meas

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_reset;
		chk({5'h0, aux, std, cs}, 8'h00, "pins at reset");
		for (int i = 0; i < 3; i++)
		begin
			rd(TVWS_IDX_TV_OUTPUT_CONTROL + 8'(i), v);
			chk(v, 8'h00, "reset value");
		end
	endtask : t_reset

	task t_regs;
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'h8c);
		chk({5'h0, aux, pwr, std}, 8'h07, "pins on");
		rd(TVWS_IDX_TV_OUTPUT_CONTROL, v);
		chk(v, 8'h8c, "ctrl read");
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'hff);
		rd(TVWS_IDX_TV_OUTPUT_CONTROL, v);
		chk(v, 8'hbf, "reserved bit");
		wr(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, 8'h5a);
		wr(TVWS_IDX_WINDOW_VSCALE_COEF_LOW, 8'ha5);
		rd(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, v);
		chk(v, 8'h5a, "h low");
		rd(TVWS_IDX_WINDOW_VSCALE_COEF_LOW, v);
		chk(v, 8'ha5, "v low");
		rd(8'h33, v);
		chk(v, 8'h00, "unmapped");
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'h00);
		chk({7'h0, aux}, 8'h00, "aux low");
	endtask : t_regs

	task t_disabled;
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'h04);
		chk({6'h0, pwr, std}, 8'h00, "disabled pins");
		meas(2'b11);
		chk(8'(tc), 8'h00, "composite_sync_out forced low");
		chk(8'(th), 8'h01, "htotal runs");
	endtask : t_disabled

	task t_override;
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'h88);
		@(negedge clk);
		ovr = 1'b1;
		ovr_lvl = 1'b0;
		#1 chk({7'h0, pwr}, 8'h00, "override low");
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'h80);
		ovr_lvl = 1'b1;
		#1 chk({7'h0, pwr}, 8'h01, "override high");
		@(negedge clk);
		ovr = 1'b0;
		#1 chk({7'h0, pwr}, 8'h00, "follows enable");
	endtask : t_override

	task t_delays;
		for (int c = 0; c < 4; c++)
			for (int n = 0; n < 2; n++)
			begin
				wr(TVWS_IDX_TV_OUTPUT_CONTROL, {2'b00, 2'(c), 1'b1, 1'(n), 2'(c)});
				chk({7'h0, std}, 8'(n), "std pin");
				meas(n ? 2'b10 : 2'b01);
				chk(8'(th), 8'(1 + 2 * c), "htotal delay");
				chk(8'(tc), 8'(1 + 2 * c), "composite_sync_out delay");
			end
		meas(2'b01);
		chk(8'(tc), 8'h00, "other standard");
	endtask : t_delays

	task t_hscale;
		coef_hi = 8'h04;
		wr(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, 8'h00);
		step(3'b010);
		for (int k = 0; k < 4; k++)
		begin
			step(3'b001);
			chk({7'h0, a}, 8'(k == 3), "h advance 4x");
			chk(pix, 8'h40 + 8'(16 * k), "interpolated");
		end
		coef_hi = 8'h0a;
		wr(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, 8'hab);
		step(3'b001);
		chk({7'h0, a}, 8'h00, "h advance aab");
		step(3'b001);
		chk({7'h0, a}, 8'h01, "h advance aab");
		chk(pix, 8'h6a, "interpolated aab");
		coef_hi = 8'h00;
		wr(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, 8'h00);
		// new line so the phase left by the last coefficient is cleared
		step(3'b010);
		for (int k = 0; k < 2; k++)
		begin
			step(3'b001);
			chk({7'h0, a}, 8'h01, "h unity");
			chk(pix, 8'h40, "unity pixel");
		end
	endtask : t_hscale

	task t_vscale;
		coef_hi = 8'h80;
		wr(TVWS_IDX_WINDOW_VSCALE_COEF_LOW, 8'h00);
		step(3'b100);
		for (int k = 0; k < 4; k++)
		begin
			step(3'b010);
			chk({7'h0, a}, 8'(k % 2), "v repeat 2x");
		end
		coef_hi = 8'h00;
		for (int k = 0; k < 2; k++)
		begin
			step(3'b010);
			chk({7'h0, a}, 8'h01, "v unity");
		end
		coef_hi = 8'h40;
		step(3'b100);
		for (int k = 0; k < 4; k++)
		begin
			step(3'b010);
			chk({7'h0, a}, 8'(k == 3), "v repeat 4x");
		end
	endtask : t_vscale

	task t_reset_mid;
		wr(TVWS_IDX_TV_OUTPUT_CONTROL, 8'h8c);
		wr(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, 8'h5a);
		rd(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, v);
		chk(v, 8'h5a, "h low before reset");
		@(negedge clk);
		nrst = 1'b0;
		@(negedge clk);
		chk({4'h0, aux, pwr, std, cs}, 8'h00, "pins in reset");
		chk(reg_rdata, 8'h00, "read data in reset");
		nrst = 1'b1;
		rd(TVWS_IDX_WINDOW_HSCALE_COEF_LOW, v);
		chk(v, 8'h00, "h low after reset");
		rd(TVWS_IDX_TV_OUTPUT_CONTROL, v);
		chk(v, 8'h00, "ctrl after reset");
	endtask : t_reset_mid

	// ---------------------------------------------------------------
	// clock, timeout, main sequence
	// ---------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			$display("BAD %0t timeout", $time);
			fail_count++;
			stop_test;
		end
	end

	initial
	begin
		{nrst, reg_wr, reg_rd, go, ovr, ovr_lvl} = 6'h0;
		{reg_index, reg_wdata, coef_hi} = 24'h0;
		{pa, pb, sel, stb} = {8'h40, 8'h80, 2'b00, 3'b000};
		{fail_count, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_reset;
		t_regs;
		t_disabled;
		t_override;
		t_delays;
		t_hscale;
		t_vscale;
		t_reset_mid;
		stop_test;
	end
endmodule : testbench
